//--- hw/sar_sequencer.sv
// Channel sequencer and control around a 12-bit SAR converter
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_sequencer (
    input  wire logic                         clock_i,
    input  wire logic                         rst_i,
    input  wire logic                         enable_i,
    input  wire logic                         deep_sleep_i,
    input  wire logic                         scan_mode_i,
    input  wire logic                         sw_start_i,
    input  wire logic [`SAR_SEL_W-1:0]        sw_channel_i,
    input  wire logic [`SAR_CHANNELS-1:0]     channel_en_i,
    input  wire logic                         temp_en_i,
    input  wire logic [`SAR_SAMP_W*9-1:0]     sample_time_i,
    input  wire sar_pkg::ref_sel_e            ref_sel_i,
    input  wire logic [`SAR_RES_W-1:0]        limit_low_i,
    input  wire logic [`SAR_RES_W-1:0]        limit_high_i,
    input  wire logic                         range_clear_i,
    input  wire logic                         eos_clear_i,
    input  wire logic                         comp_i,
    input  wire logic [`SAR_SEL_W-1:0]        rd_channel_i,
    input  wire logic                         res_ready_i,
    output logic [`SAR_SEL_W-1:0]             mux_sel_o,
    output logic                              sample_o,
    output logic [1:0]                        ref_sel_o,
    output logic [`SAR_RES_W-1:0]             dac_code_o,
    output logic [`SAR_RES_W-1:0]             rd_value_o,
    output logic                              range_irq_o,
    output logic                              eos_flag_o,
    output logic                              busy_o,
    output sar_pkg::result_s                  res_data_o,
    output logic                              res_valid_o,
    output logic                              overflow_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sar_pkg::seq_state_e        state;
    logic [`SAR_SEL_W-1:0]      cur_ch;
    logic [`SAR_SAMP_W-1:0]     samp_cnt;
    logic [`SAR_CONV_CNT_W-1:0] conv_cnt;
    logic [`SAR_RES_W-1:0]      sar_reg;
    logic [`SAR_RES_W-1:0]      result_buf [`SAR_CHANNELS+1];
    logic [`SAR_CHANNELS:0]     active_mask;
    logic [`SAR_SEL_W-1:0]      next_ch;
    logic                       wrap;
    logic                       conv_done;
    logic [`SAR_RES_W-1:0]      final_val;
    logic                       outside;
    logic                       fifo_in_ready;
    logic                       run;
    sar_pkg::result_s           fifo_out;
    logic                       fifo_valid;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // One-hot mask of the trial bit of a successive-approximation step
    function automatic logic [`SAR_RES_W-1:0] step_bit(
        input logic [`SAR_CONV_CNT_W-1:0] cnt
    );
        step_bit = `SAR_RES_W'(1) << (`SAR_RES_W - 1 - int'(cnt));
    endfunction

    // Sample window length of a channel
    function automatic logic [`SAR_SAMP_W-1:0] samp_of(
        input logic [`SAR_SEL_W-1:0] ch
    );
        logic [`SAR_SAMP_W-1:0] t;
        t = sample_time_i[ch*`SAR_SAMP_W +: `SAR_SAMP_W];
        // Floor keeps every conversion at or above its minimum length
        if (t < `SAR_SAMP_W'(`SAR_CONV_CYCLES - `SAR_RES_W - 1)) begin
            t = `SAR_SAMP_W'(`SAR_CONV_CYCLES - `SAR_RES_W - 1);
        end
        samp_of = t;
    endfunction

    // Code after the decision on the current trial bit
    function automatic logic [`SAR_RES_W-1:0] decide(
        input logic [`SAR_RES_W-1:0]      code,
        input logic [`SAR_CONV_CNT_W-1:0] cnt,
        input logic                       keep
    );
        decide = keep ? code : (code & ~step_bit(cnt));
    endfunction

    // Lowest enabled channel of a mask
    function automatic logic [`SAR_SEL_W-1:0] lowest_ch(
        input logic [`SAR_CHANNELS:0] mask
    );
        lowest_ch = '0;
        for (int i = `SAR_CHANNELS; i >= 0; i--) begin
            if (mask[i]) begin
                lowest_ch = `SAR_SEL_W'(i);
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Channel selection
    // ------------------------------------------------------------
    assign active_mask = {temp_en_i, channel_en_i};
    assign run = enable_i && !deep_sleep_i && fifo_in_ready;

    always_comb begin
        next_ch = cur_ch;
        wrap    = 1'b1;
        for (int i = `SAR_CHANNELS; i >= 0; i--) begin
            if (active_mask[i] && (i > int'(cur_ch))) begin
                next_ch = `SAR_SEL_W'(i);
                wrap    = 1'b0;
            end
        end
        if (wrap) begin
            next_ch = lowest_ch(active_mask);
        end
    end

    // ------------------------------------------------------------
    // Conversion engine
    // ------------------------------------------------------------
    assign conv_done = (state == sar_pkg::ST_CONV) &&
                       (conv_cnt == `SAR_CONV_CNT_W'(`SAR_RES_W - 1));
    assign final_val = decide(sar_reg, conv_cnt, comp_i);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state    <= sar_pkg::ST_IDLE;
            cur_ch   <= '0;
            samp_cnt <= '0;
            conv_cnt <= '0;
            sar_reg  <= '0;
        end else begin
            case (state)
                sar_pkg::ST_IDLE: begin
                    if (run && scan_mode_i && |active_mask) begin
                        cur_ch   <= lowest_ch(active_mask);
                        samp_cnt <= samp_of(lowest_ch(active_mask));
                        state    <= sar_pkg::ST_SAMPLE;
                    end else if (run && !scan_mode_i && sw_start_i &&
                                 int'(sw_channel_i) <= `SAR_CHANNELS) begin
                        cur_ch   <= sw_channel_i;
                        samp_cnt <= samp_of(sw_channel_i);
                        state    <= sar_pkg::ST_SAMPLE;
                    end
                end
                sar_pkg::ST_SAMPLE: begin
                    if (samp_cnt == '0) begin
                        conv_cnt <= '0;
                        sar_reg  <= step_bit('0);
                        state    <= sar_pkg::ST_CONV;
                    end else begin
                        samp_cnt <= samp_cnt - 1'b1;
                    end
                end
                sar_pkg::ST_CONV: begin
                    if (conv_done) begin
                        if (run && scan_mode_i && |active_mask) begin
                            cur_ch   <= next_ch;
                            samp_cnt <= samp_of(next_ch);
                            state    <= sar_pkg::ST_SAMPLE;
                        end else begin
                            state <= sar_pkg::ST_IDLE;
                        end
                    end else begin
                        conv_cnt <= conv_cnt + 1'b1;
                        sar_reg  <= final_val | step_bit(conv_cnt + 1'b1);
                    end
                end
                default: begin
                    state <= sar_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result buffers and limit check
    // ------------------------------------------------------------
    sar_limit_check u_limit (
        .value_i   (final_val),
        .low_i     (limit_low_i),
        .high_i    (limit_high_i),
        .outside_o (outside)
    );

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i <= `SAR_CHANNELS; i++) begin
                result_buf[i] <= '0;
            end
        end else if (conv_done) begin
            result_buf[cur_ch] <= final_val;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            range_irq_o <= 1'b0;
        end else if (conv_done && outside) begin
            range_irq_o <= 1'b1;
        end else if (range_clear_i) begin
            range_irq_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            eos_flag_o <= 1'b0;
        end else if (conv_done && scan_mode_i && wrap) begin
            eos_flag_o <= 1'b1;
        end else if (eos_clear_i) begin
            eos_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_o <= 1'b0;
        end else if (conv_done && !fifo_in_ready) begin
            overflow_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Result stream
    // ------------------------------------------------------------
    sar_fifo #(
        .WIDTH ($bits(sar_pkg::result_s)),
        .DEPTH (`SAR_FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_data_i   ({cur_ch, final_val}),
        .in_valid_i  (conv_done),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out),
        .out_valid_o (fifo_valid),
        .out_ready_i (!res_valid_o || res_ready_i)
    );

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            res_data_o  <= '0;
            res_valid_o <= 1'b0;
        end else if (!res_valid_o || res_ready_i) begin
            res_valid_o <= fifo_valid;
            res_data_o  <= fifo_out;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mux_sel_o <= '0;
            sample_o  <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            mux_sel_o <= cur_ch;
            sample_o  <= state == sar_pkg::ST_SAMPLE;
            busy_o    <= state != sar_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ref_sel_o <= 2'h0;
        end else begin
            ref_sel_o <= ref_sel_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rd_value_o <= '0;
        end else begin
            rd_value_o <= (int'(rd_channel_i) <= `SAR_CHANNELS)
                          ? result_buf[rd_channel_i] : '0;
        end
    end

    // Trial code goes straight from the SAR register to the comparator
    assign dac_code_o = sar_reg;
endmodule // sar_sequencer
`default_nettype wire

//--- shared/sar_params.svh
// Constants for the converter channel sequencer
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define SAR_CHANNELS      8
`define SAR_CH_W          3
`define SAR_RES_W         12
`define SAR_SAMP_W        8
`define SAR_CONV_CYCLES   18
`define SAR_CONV_CNT_W    5
`define SAR_FIFO_DEPTH    16
`define SAR_TEMP_INDEX    4'h8
`define SAR_SEL_W         4
`define SAR_CLK_MHZ       40
`define SAR_MAX_CONV_MHZ  18
`endif

//--- shared/sar_pkg.sv
// Types for the converter channel sequencer
package sar_pkg;
    typedef enum logic [1:0] {
        REF_VDD      = 2'h0,
        REF_VDD_HALF = 2'h1,
        REF_BANDGAP  = 2'h2,
        REF_EXTERNAL = 2'h3
    } ref_sel_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_CONV   = 2'h3
    } seq_state_e;

    typedef struct packed {
        logic [3:0]  channel;
        logic [11:0] value;
    } result_s;
endpackage

//--- hw/sar_fifo.sv
// Parameterised valid/ready FIFO for conversion results
`timescale 1ns/1ps
`default_nettype none
module sar_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // sar_fifo
`default_nettype wire

//--- hw/sar_limit_check.sv
// Window comparator of a result against low and high limits
`timescale 1ns/1ps
`default_nettype none
module sar_limit_check (
    input  wire logic [11:0] value_i,
    input  wire logic [11:0] low_i,
    input  wire logic [11:0] high_i,
    output logic             outside_o
);
    assign outside_o = (value_i < low_i) || (value_i > high_i);
endmodule // sar_limit_check
`default_nettype wire

//--- dv/sar_sequencer_props.sv
// Port checker for the converter channel sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_sequencer_props (
    input wire logic                     clock_i,
    input wire logic                     rst_i,
    input wire logic                     enable_i,
    input wire logic                     deep_sleep_i,
    input wire logic                     scan_mode_i,
    input wire logic [`SAR_CHANNELS-1:0] channel_en_i,
    input wire logic                     temp_en_i,
    input wire logic [`SAR_SAMP_W*9-1:0] sample_time_i,
    input wire sar_pkg::ref_sel_e        ref_sel_i,
    input wire logic                     range_clear_i,
    input wire logic                     eos_clear_i,
    input wire logic [`SAR_SEL_W-1:0]    rd_channel_i,
    input wire logic                     res_ready_i,
    input wire logic [`SAR_SEL_W-1:0]    mux_sel_o,
    input wire logic                     sample_o,
    input wire logic [1:0]               ref_sel_o,
    input wire logic [`SAR_RES_W-1:0]    rd_value_o,
    input wire logic                     range_irq_o,
    input wire logic                     eos_flag_o,
    input wire sar_pkg::result_s         res_data_o,
    input wire logic                     res_valid_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic [8:0] samp_cnt;
    // ------------------------------------------------------------
    // Length of the current sample window
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) samp_cnt <= 9'h000;
        else if (sample_o) samp_cnt <= samp_cnt + 9'h001;
        else samp_cnt <= 9'h000;
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_REF_PIPE: assert property (
        !$past(rst_i) |-> ref_sel_o == $past(ref_sel_i))
        else $error("reference select not passed on");
    AST_SAMPLE_LEN: assert property (
        $fell(sample_o) |-> samp_cnt ==
            {1'b0, sample_time_i[mux_sel_o*8 +: 8]} + 9'h001)
        else $error("sample window length wrong");
    AST_START_GAP: assert property (
        $rose(sample_o) |=> !$rose(sample_o)[*8] ##1
            !$rose(sample_o)[*8] ##1 !$rose(sample_o))
        else $error("conversion shorter than minimum");
    AST_MUX_HOLD: assert property (
        sample_o && $past(sample_o) |-> $stable(mux_sel_o))
        else $error("channel changed while sampling");
    AST_SCAN_PICK: assert property (
        $rose(sample_o) && scan_mode_i |-> ((mux_sel_o == 4'h8) ?
            temp_en_i : channel_en_i[mux_sel_o[2:0]]))
        else $error("scan picked a disabled channel");
    AST_RANGE_HOLD: assert property (
        range_irq_o && !range_clear_i |=> range_irq_o)
        else $error("range flag lost");
    AST_EOS_HOLD: assert property (
        eos_flag_o && !eos_clear_i |=> eos_flag_o)
        else $error("end of scan flag lost");
    AST_SLEEP_HALT: assert property (
        $rose(sample_o) |-> !$past(deep_sleep_i, 2) && $past(enable_i, 2))
        else $error("channel started while halted");
    AST_RD_EMPTY: assert property (
        !$past(rst_i) && $past(rd_channel_i) > 4'h8 |-> rd_value_o == 12'h000)
        else $error("empty buffer slot not zero");
    AST_VALID_HOLD: assert property (
        res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o))
        else $error("result dropped before taken");
    COV_SCAN: cover property ($rose(sample_o) && scan_mode_i);
    COV_RANGE: cover property ($rose(range_irq_o));
    COV_EOS: cover property ($rose(eos_flag_o));
    COV_STALL: cover property (res_valid_o && !res_ready_i);
endmodule // sar_sequencer_props
bind sar_sequencer sar_sequencer_props u_props (.clock_i(clock_i),
    .rst_i(rst_i), .enable_i(enable_i), .deep_sleep_i(deep_sleep_i),
    .scan_mode_i(scan_mode_i), .channel_en_i(channel_en_i),
    .temp_en_i(temp_en_i), .sample_time_i(sample_time_i),
    .ref_sel_i(ref_sel_i), .range_clear_i(range_clear_i),
    .eos_clear_i(eos_clear_i), .rd_channel_i(rd_channel_i),
    .res_ready_i(res_ready_i), .mux_sel_o(mux_sel_o), .sample_o(sample_o),
    .ref_sel_o(ref_sel_o), .rd_value_o(rd_value_o),
    .range_irq_o(range_irq_o), .eos_flag_o(eos_flag_o),
    .res_data_o(res_data_o), .res_valid_o(res_valid_o));
`default_nettype wire

//--- dv/sar_front_model.sv
// Analog front end model: input mux, sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_front_model (
    input  wire logic                    clock_i,
    input  wire logic [`SAR_SEL_W-1:0]   mux_sel_i,
    input  wire logic                    sample_i,
    input  wire logic [`SAR_RES_W-1:0]   dac_code_i,
    input  wire logic [`SAR_RES_W*9-1:0] level_i,
    output logic                         comp_o
);
    logic [`SAR_RES_W-1:0] held;
    always_ff @(posedge clock_i) begin
        if (sample_i) held <= level_i[mux_sel_i*12 +: 12];
    end
    assign comp_o = held >= dac_code_i;
endmodule // sar_front_model
`default_nettype wire

//--- dv/sar_sequencer_bench.sv
// Self-checking bench of the converter channel sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_sequencer_bench;
    logic clock_i = 1'b0, rst_i = 1'b1, enable_i, deep_sleep_i, scan_mode_i;
    logic sw_start_i, temp_en_i, range_clear_i, eos_clear_i, res_ready_i;
    logic comp_i, sample_o, range_irq_o, eos_flag_o, busy_o;
    logic res_valid_o, overflow_o, exp_irq;
    logic [3:0] sw_channel_i, rd_channel_i, mux_sel_o;
    logic [7:0] channel_en_i;
    logic [71:0] sample_time_i;
    logic [11:0] limit_low_i, limit_high_i, dac_code_o, rd_value_o, v;
    logic [1:0] ref_sel_o;
    logic [107:0] level;
    sar_pkg::ref_sel_e ref_sel_i;
    sar_pkg::result_s res_data_o;
    logic [31:0] seed = 32'hCC0140BB;
    int n_mismatch = 0, check_count = 0, cyc = 0, at, t0, k;
    int scan_seq[7] = '{1, 2, 5, 7, 8, 1, 2};
    sar_sequencer u_dut (.clock_i(clock_i), .rst_i(rst_i),
        .enable_i(enable_i), .deep_sleep_i(deep_sleep_i),
        .scan_mode_i(scan_mode_i), .sw_start_i(sw_start_i),
        .sw_channel_i(sw_channel_i), .channel_en_i(channel_en_i),
        .temp_en_i(temp_en_i), .sample_time_i(sample_time_i),
        .ref_sel_i(ref_sel_i), .limit_low_i(limit_low_i),
        .limit_high_i(limit_high_i), .range_clear_i(range_clear_i),
        .eos_clear_i(eos_clear_i), .comp_i(comp_i),
        .rd_channel_i(rd_channel_i), .res_ready_i(res_ready_i),
        .mux_sel_o(mux_sel_o), .sample_o(sample_o), .ref_sel_o(ref_sel_o),
        .dac_code_o(dac_code_o), .rd_value_o(rd_value_o),
        .range_irq_o(range_irq_o), .eos_flag_o(eos_flag_o),
        .busy_o(busy_o), .res_data_o(res_data_o),
        .res_valid_o(res_valid_o), .overflow_o(overflow_o));
    sar_front_model u_front (.clock_i(clock_i), .mux_sel_i(mux_sel_o),
        .sample_i(sample_o), .dac_code_i(dac_code_o), .level_i(level),
        .comp_o(comp_i));
    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic start_only(input logic [3:0] ch, input logic [11:0] val,
                              input logic [1:0] rs);
        @(posedge clock_i);
        if (ch < 4'h9) level[ch*12 +: 12] <= val;
        ref_sel_i <= sar_pkg::ref_sel_e'(rs);
        sw_channel_i <= ch;
        sw_start_i <= 1'b1;
        @(posedge clock_i);
        sw_start_i <= 1'b0;
    endtask
    task automatic wait_sig(input int sel);
        at = 0;
        do begin
            @(negedge clock_i);
            at++;
        end while (((sel == 0) ? res_valid_o : busy_o) !== (sel == 0)
                   && at < 800);
    endtask
    task automatic next_rise();
        logic prev;
        prev = 1'b1;
        at = 0;
        @(negedge clock_i);
        while (!(sample_o === 1'b1 && prev === 1'b0) && at < 400) begin
            prev = sample_o;
            @(negedge clock_i);
            at++;
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {enable_i, deep_sleep_i, scan_mode_i, sw_start_i} = 4'h8;
        {temp_en_i, range_clear_i, eos_clear_i, res_ready_i} = 4'h8;
        {sw_channel_i, rd_channel_i, channel_en_i} = 16'h00A6;
        {limit_low_i, limit_high_i} = {12'h300, 12'hC00};
        ref_sel_i = sar_pkg::REF_VDD;
        level = '0;
        for (int c = 0; c < 9; c++) sample_time_i[c*8 +: 8] = 8'h05 + (rnd() & 15);
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            v = (i == 9) ? 12'h300 : (i == 10) ? 12'hC01 : rnd();
            start_only(i % 9, v, i);
            wait_sig(0);
            exp_irq = (v < limit_low_i) || (v > limit_high_i);
            check(res_data_o, {i % 9, v});
            check(range_irq_o, exp_irq);
            check(ref_sel_o, i % 4);
            @(posedge clock_i);
            {rd_channel_i, res_ready_i, range_clear_i} <= {4'(i % 9), 2'h3};
            @(posedge clock_i);
            {res_ready_i, range_clear_i} <= 2'h0;
            @(negedge clock_i);
            check(rd_value_o, v);
        end
        start_only(4'h9, 12'h000, 2'h0);
        repeat (3) @(negedge clock_i);
        check(busy_o, 1'b0);
        @(posedge clock_i);
        deep_sleep_i <= 1'b1;
        start_only(4'h0, 12'h100, 2'h0);
        repeat (3) @(negedge clock_i);
        check(busy_o, 1'b0);
        @(posedge clock_i);
        level <= {{7{12'h500}}, 12'hF00, 12'h500};
        rd_channel_i <= 4'hF;
        {sample_time_i, deep_sleep_i} <= {{9{8'h05}}, 1'b0};
        {scan_mode_i, res_ready_i} <= 2'h3;
        for (int n = 0; n < 7; n++) begin
            next_rise();
            check(mux_sel_o, scan_seq[n]);
            if (n == 0) check(rd_value_o, 12'h000);
            if (n > 0) check(cyc - t0, 18);
            if (n == 2) check({range_irq_o, eos_flag_o}, 2'h2);
            if (n == 6) check(eos_flag_o, 1'b1);
            t0 = cyc;
        end
        @(posedge clock_i);
        scan_mode_i <= 1'b0;
        wait_sig(1);
        @(posedge clock_i);
        {range_clear_i, eos_clear_i} <= 2'h3;
        @(posedge clock_i);
        {range_clear_i, eos_clear_i, res_ready_i, scan_mode_i} <= 4'h1;
        @(negedge clock_i);
        check({range_irq_o, eos_flag_o}, 2'h0);
        repeat (700) @(posedge clock_i);
        scan_mode_i <= 1'b0;
        @(negedge clock_i);
        check(busy_o, 1'b0);
        @(posedge clock_i);
        res_ready_i <= 1'b1;
        k = 0;
        repeat (40) begin
            @(negedge clock_i);
            if (res_valid_o === 1'b1 && res_ready_i === 1'b1) begin
                v = (scan_seq[k % 5] == 1) ? 12'hF00 : 12'h500;
                check(res_data_o, {4'(scan_seq[k % 5]), v});
                k++;
            end
        end
        check(k >= 16, 1'b1);
        check(overflow_o, 1'b1);
        print_verdict();
    end
endmodule // sar_sequencer_bench
`default_nettype wire
